// file: hw/pc_card_modem_config_decode.sv
// card-side configuration registers and address decode for a pc card modem
// assumes socket strobes are asynchronous pins, synchronised here; single clock CLK
module pc_card_modem_config_decode #(
    parameter int unsigned RING_TIMEOUT_CYC = pcc_pkg::RING_TIMEOUT_CYC,
    parameter int unsigned WAKE_PULSE_CYC   = pcc_pkg::WAKE_PULSE_CYC
) (
    input  wire logic            CLK,
    input  wire logic            RSTN,
    input  wire pcc_pkg::addr_t  ADDR,
    input  wire pcc_pkg::data_t  DATA_IN,
    output var  pcc_pkg::data_t  DATA_OUT,
    output logic                 DATA_OE,
    input  wire logic            CARD_ENABLE_N,
    input  wire logic            REG_SELECT_N,
    input  wire logic            OUTPUT_ENABLE_N,
    input  wire logic            WRITE_ENABLE_N,
    input  wire logic            IO_READ_N,
    input  wire logic            IO_WRITE_N,
    input  wire logic            CARD_RESET,
    input  wire logic            RING_DETECT_IN,
    input  wire logic            MODEM_IRQ_IN,
    input  wire logic            MODEM_READY_IN,
    input  wire logic            SPEAKER_BIT_IN,
    output logic                 INFO_TABLE_CHIP_SELECT_N,
    output logic                 MODEM_CHIP_SELECT_N,
    output logic                 INPUT_ACK_N,
    output logic                 IRQ_READY_N,
    output logic                 STATUS_CHANGE_N,
    output logic                 SPEAKER_BIT_OUT,
    output logic                 SPEAKER_BIT_OE,
    output logic                 RING_OUT_FIRST_FAMILY,
    output logic                 RING_OUT_SECOND_FAMILY,
    output logic                 MODEM_RESET_N,
    output logic                 POWER_DOWN_N
);
    import pcc_pkg::*;

    ring_if rif ();

    logic [SYNC_W-1:0] pin_raw;
    logic [SYNC_W-1:0] s1_r;
    logic [SYNC_W-1:0] s2_r;
    logic [SYNC_W-1:0] s3_r;
    logic              soft_r;
    idx_t              idx_r;
    logic              sig_en_r;
    logic              ros_r;
    logic              audio_r;
    logic              pd_r;
    logic              ring_en_r;
    logic              ring_flag_r;
    logic              ready_r;
    logic              rdy_chg_r;
    pm_state_t         pm_r;
    wake_cnt_t         wake_r;
    addr_t             addr;
    addr_t             wr_addr;
    data_t             wd;
    logic              attr_now;
    logic              wr_end;
    logic              dev_rst;
    logic              crst;
    logic              rdy_rise;
    logic              rdy_fall;
    logic              changed;
    logic              io_sel;

    // is this offset one of the four configuration registers
    function automatic logic reg_hit(input addr_t a);
        return (a == OFS_COR) || (a == OFS_CARD_CONFIG_STATUS) || (a == OFS_PRR) || (a == OFS_IOE);
    endfunction

    // io window decode from the configuration index
    function automatic logic io_window_hit(input idx_t idx, input addr_t a);
        addr_t base;
        base = WIN_0;
        unique case (idx[1:0])
            2'b00: base = WIN_0;
            2'b01: base = WIN_1;
            2'b10: base = WIN_2;
            2'b11: base = WIN_3;
        endcase
        if (!idx[IDX_EN_B])
            return 1'b0;
        if (idx[IDX_ALL_B])
            return 1'b1;
        return a[ADDR_W-1:WIN_LSB] == base[ADDR_W-1:WIN_LSB];
    endfunction

    // ring detect pin is handled by its own detector
    ring_activity_detect #(
        .RING_TIMEOUT_CYC (RING_TIMEOUT_CYC)
    ) u_ring (
        .clk      (CLK),
        .rstn     (RSTN),
        .ring_pin (RING_DETECT_IN),
        .det      (rif.det)
    );

    // synchronise socket and modem pins, third stage for edges
    assign pin_raw = {SPEAKER_BIT_IN, MODEM_READY_IN, MODEM_IRQ_IN, CARD_RESET,
                      ~IO_WRITE_N, ~IO_READ_N, ~WRITE_ENABLE_N, ~OUTPUT_ENABLE_N,
                      ~REG_SELECT_N, ~CARD_ENABLE_N, DATA_IN, ADDR};
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= pin_raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // decode of the current and the previous sampled cycle
    assign addr     = s2_r[A_LSB +: ADDR_W];
    assign wr_addr  = s3_r[A_LSB +: ADDR_W];
    assign wd       = s3_r[D_LSB +: DATA_W];
    assign crst     = s2_r[CRST_B];
    assign dev_rst  = crst | soft_r;
    assign rdy_rise = s2_r[RDY_B] & ~s3_r[RDY_B];
    assign rdy_fall = ~s2_r[RDY_B] & s3_r[RDY_B];
    // attribute space needs reg select; even addresses only
    assign attr_now = s2_r[CE_B] & s2_r[REG_B] & ~addr[0] & ~s2_r[IORD_B] & ~s2_r[IOWR_B];
    // write taken when the write strobe ends, using the data held before it
    assign wr_end   = s3_r[WE_B] & ~s2_r[WE_B] & s3_r[CE_B] & s3_r[REG_B] & ~wr_addr[0];

    // option register, soft reset and index
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            soft_r <= 1'b0;
            idx_r  <= '0;
        end else if (crst) begin
            soft_r <= 1'b0;
            idx_r  <= '0;
        end else if (wr_end && wr_addr == OFS_COR) begin
            // bit stays set, device left unconfigured
            soft_r <= wd[COR_SRST_B];
            idx_r  <= wd[COR_SRST_B] ? idx_t'(0) : wd[IDX_W-1:0];
        end else if (soft_r) begin
            idx_r <= '0;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            sig_en_r <= 1'b0;
            ros_r    <= 1'b0;
            audio_r  <= 1'b0;
            pd_r     <= 1'b0;
        end else if (dev_rst) begin
            sig_en_r <= 1'b0;
            ros_r    <= 1'b0;
            audio_r  <= 1'b0;
            pd_r     <= 1'b0;
        end else if (wr_end && wr_addr == OFS_CARD_CONFIG_STATUS) begin
            sig_en_r <= wd[CARD_CONFIG_STATUS_SIG_B];
            ros_r    <= wd[CARD_CONFIG_STATUS_ROS_B];
            audio_r  <= wd[CARD_CONFIG_STATUS_AUD_B];
            pd_r     <= wd[CARD_CONFIG_STATUS_PD_B];
        end
    end

    // enable bit, written independently of the flag
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ring_en_r <= 1'b0;
        end else if (dev_rst) begin
            ring_en_r <= 1'b0;
        end else if (wr_end && wr_addr == OFS_IOE) begin
            ring_en_r <= wd[IOE_EN_B];
        end
    end

    // ring event flag, set wins over a clearing write
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ring_flag_r <= 1'b0;
        end else if (dev_rst) begin
            ring_flag_r <= 1'b0;
        end else if (rif.ring_start) begin
            ring_flag_r <= 1'b1;
        end else if (wr_end && wr_addr == OFS_IOE && wd[IOE_FLAG_B]) begin
            ring_flag_r <= 1'b0;
        end
    end

    // internal ready, busy until the modem ready input rises
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ready_r <= 1'b0;
        end else if (dev_rst) begin
            ready_r <= 1'b0;
        end else if (rdy_rise) begin
            ready_r <= 1'b1;
        end else if (rdy_fall) begin
            ready_r <= 1'b0;
        end
    end

    // ready change flag, hardware toggle wins over host write
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rdy_chg_r <= 1'b0;
        end else if (dev_rst) begin
            rdy_chg_r <= 1'b0;
        end else if ((rdy_rise && !ready_r) || (rdy_fall && ready_r)) begin
            rdy_chg_r <= 1'b1;
        end else if (wr_end && wr_addr == OFS_PRR && wd[PRR_RDY_B]) begin
            rdy_chg_r <= wd[PRR_CHG_B];
        end
    end

    // changed bit; enabled ring event contribution
    assign changed = rdy_chg_r | (ring_flag_r & ring_en_r);

    // power-down sequencing with a wake pulse
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pm_r   <= PM_RUN;
            wake_r <= '0;
        end else if (dev_rst) begin
            pm_r   <= PM_RUN;
            wake_r <= '0;
        end else begin
            unique case (pm_r)
                PM_RUN: begin
                    if (pd_r)
                        pm_r <= PM_DOWN;
                end
                PM_DOWN: begin
                    if (!pd_r) begin
                        pm_r   <= PM_WAKE;
                        wake_r <= wake_cnt_t'(WAKE_PULSE_CYC);
                    end
                end
                PM_WAKE: begin
                    if (pd_r)
                        pm_r <= PM_DOWN;
                    else if (wake_r <= wake_cnt_t'(1))
                        pm_r <= PM_RUN;
                    wake_r <= wake_r - wake_cnt_t'(1);
                end
                default: pm_r <= PM_RUN;
            endcase
        end
    end

    // io cycle select; blocked unless running; window decode
    assign io_sel = s2_r[CE_B] & s2_r[REG_B] & (s2_r[IORD_B] | s2_r[IOWR_B])
                  & io_window_hit(idx_r, addr) & (pm_r == PM_RUN) & ~pd_r & ~dev_rst;

    // chip selects and io acknowledge
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            MODEM_CHIP_SELECT_N      <= 1'b1;
            INPUT_ACK_N              <= 1'b1;
            INFO_TABLE_CHIP_SELECT_N <= 1'b1;
        end else begin
            MODEM_CHIP_SELECT_N      <= ~io_sel;
            INPUT_ACK_N              <= ~(io_sel & s2_r[IORD_B]);
            INFO_TABLE_CHIP_SELECT_N <= ~(attr_now & (addr <= CIS_LAST));
        end
    end

    // register read data, reserved bits zero; ready; interrupt
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            DATA_OUT <= REG_RESET;
            DATA_OE  <= 1'b0;
        end else begin
            DATA_OE  <= attr_now & s2_r[OE_B] & reg_hit(addr);
            DATA_OUT <= REG_RESET;
            if (addr == OFS_COR) begin
                DATA_OUT[COR_SRST_B]  <= soft_r;
                DATA_OUT[IDX_W-1:0]   <= idx_r;
            end else if (addr == OFS_CARD_CONFIG_STATUS) begin
                DATA_OUT[CARD_CONFIG_STATUS_CHG_B] <= changed;
                DATA_OUT[CARD_CONFIG_STATUS_SIG_B] <= sig_en_r;
                DATA_OUT[CARD_CONFIG_STATUS_ROS_B] <= ros_r;
                DATA_OUT[CARD_CONFIG_STATUS_AUD_B] <= audio_r;
                DATA_OUT[CARD_CONFIG_STATUS_PD_B]  <= pd_r;
                DATA_OUT[CARD_CONFIG_STATUS_INT_B] <= s2_r[IRQ_B];
            end else if (addr == OFS_PRR) begin
                DATA_OUT[PRR_CHG_B]  <= rdy_chg_r;
                DATA_OUT[PRR_RDY_B]  <= ready_r;
            end else if (addr == OFS_IOE) begin
                DATA_OUT[IOE_FLAG_B] <= ring_flag_r;
                DATA_OUT[IOE_EN_B]   <= ring_en_r;
            end
        end
    end

    // status change, interrupt/ready, speaker and modem control pins
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            STATUS_CHANGE_N <= 1'b1;
            IRQ_READY_N     <= 1'b0;
            SPEAKER_BIT_OUT <= 1'b0;
            SPEAKER_BIT_OE  <= 1'b0;
            MODEM_RESET_N   <= 1'b0;
            POWER_DOWN_N    <= 1'b1;
        end else begin
            // ring mode; changed mode; idle high
            if (ros_r)
                STATUS_CHANGE_N <= ~rif.ringing;
            else
                STATUS_CHANGE_N <= ~(sig_en_r & changed);
            // busy/ready until configured, then inverted interrupt
            IRQ_READY_N     <= idx_r[IDX_EN_B] ? ~s2_r[IRQ_B] : ready_r;
            SPEAKER_BIT_OUT <= audio_r & s2_r[SPK_B];
            SPEAKER_BIT_OE  <= audio_r;
            MODEM_RESET_N   <= ~dev_rst;
            POWER_DOWN_N    <= ~pd_r;
        end
    end

    // ring outputs blocked in power-down, pulsed on wake
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            RING_OUT_FIRST_FAMILY  <= 1'b1;
            RING_OUT_SECOND_FAMILY <= 1'b0;
        end else if (pm_r == PM_DOWN || (pm_r == PM_RUN && pd_r)) begin
            RING_OUT_FIRST_FAMILY  <= 1'b0;
            RING_OUT_SECOND_FAMILY <= 1'b0;
        end else if (pm_r == PM_WAKE) begin
            RING_OUT_FIRST_FAMILY  <= 1'b0;
            RING_OUT_SECOND_FAMILY <= 1'b1;
        end else begin
            RING_OUT_FIRST_FAMILY  <= ~(rif.ringing & rif.ring_level);
            RING_OUT_SECOND_FAMILY <= rif.ring_level;
        end
    end

    // checks on the guarded behaviour
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    a_common_none: assert property (!s2_r[REG_B] |=> INFO_TABLE_CHIP_SELECT_N && MODEM_CHIP_SELECT_N && !DATA_OE)
        else $error("common memory cycle selected something");
    a_pd_mcs_high: assert property (pd_r |=> MODEM_CHIP_SELECT_N)
        else $error("chip select asserted in power-down");
    a_pd_ring_block: assert property (pm_r == PM_DOWN |=> !RING_OUT_FIRST_FAMILY && !RING_OUT_SECOND_FAMILY)
        else $error("ring passed through in power-down");
    a_wake_pulse_out: assert property ($rose(pm_r == PM_WAKE) |=> !RING_OUT_FIRST_FAMILY && RING_OUT_SECOND_FAMILY)
        else $error("no wake pulse after power-down");
    a_ring_flag_set: assert property (rif.ring_start && !dev_rst |=> ring_flag_r)
        else $error("ring start did not set the flag");
    a_ring_flag_clear: assert property (wr_end && wr_addr == OFS_IOE && wd[IOE_FLAG_B] && !rif.ring_start && !dev_rst
                                        |=> !ring_flag_r)
        else $error("write of one did not clear ring flag");
    a_rdy_chg_set: assert property ($changed(ready_r) && !$past(dev_rst) |-> rdy_chg_r)
        else $error("ready toggle did not set change flag");
    a_sig_changed: assert property (sig_en_r && !ros_r && changed |=> !STATUS_CHANGE_N)
        else $error("status change not low while changed");
    a_stschg_idle: assert property (!sig_en_r && !ros_r |=> STATUS_CHANGE_N)
        else $error("status change low with both enables off");
    a_stschg_ring: assert property (ros_r |=> STATUS_CHANGE_N == !$past(rif.ringing))
        else $error("status change does not follow ringing");
    a_speaker_tri: assert property (!audio_r |=> !SPEAKER_BIT_OE)
        else $error("speaker driven with audio off");
    a_reset_hold: assert property (crst |=> !MODEM_RESET_N && idx_r == '0)
        else $error("card reset not holding modem reset");
    a_busy_after_rst: assert property (!idx_r[IDX_EN_B] && !ready_r |=> !IRQ_READY_N)
        else $error("ready shown before modem ready edge");

    c_ring_event: cover property (rif.ring_start ##1 ring_flag_r);
    c_wake_seq: cover property (pm_r == PM_DOWN ##1 pm_r == PM_WAKE);
    c_io_select: cover property (!MODEM_CHIP_SELECT_N && !INPUT_ACK_N);
    c_reg_write: cover property (wr_end && wr_addr == OFS_CARD_CONFIG_STATUS);

endmodule

// file: hw/pcc_pkg.sv
// constants, register map and types for the pc card modem configuration block
// assumes a single 125 MHz clock and a 10-bit attribute/io address from the socket
package pcc_pkg;

    // clock rate and derived timing
    localparam int unsigned CLK_MHZ          = 125;
    localparam int unsigned RING_TIMEOUT_MS  = 100;
    localparam int unsigned RING_TIMEOUT_CYC = RING_TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int unsigned WAKE_PULSE_US    = 10;
    localparam int unsigned WAKE_PULSE_CYC   = WAKE_PULSE_US * CLK_MHZ;

    // bus widths
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int IDX_W  = 6;

    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [DATA_W-1:0] data_t;
    typedef logic [IDX_W-1:0]  idx_t;
    typedef logic [23:0]       ring_cnt_t;
    typedef logic [15:0]       wake_cnt_t;

    // attribute memory map
    localparam addr_t CIS_LAST = 10'h1FF;
    localparam addr_t OFS_COR  = 10'h200;
    localparam addr_t OFS_CARD_CONFIG_STATUS = 10'h202;
    localparam addr_t OFS_PRR  = 10'h204;
    localparam addr_t OFS_IOE  = 10'h208;
    localparam data_t REG_RESET = 8'h00;

    // field positions
    localparam int COR_SRST_B = 7;
    localparam int IDX_EN_B   = 5;
    localparam int IDX_ALL_B  = 4;
    localparam int CARD_CONFIG_STATUS_CHG_B = 7;
    localparam int CARD_CONFIG_STATUS_SIG_B = 6;
    localparam int CARD_CONFIG_STATUS_ROS_B = 4;
    localparam int CARD_CONFIG_STATUS_AUD_B = 3;
    localparam int CARD_CONFIG_STATUS_PD_B  = 2;
    localparam int CARD_CONFIG_STATUS_INT_B = 1;
    localparam int PRR_CHG_B  = 5;
    localparam int PRR_RDY_B  = 1;
    localparam int IOE_FLAG_B = 4;
    localparam int IOE_EN_B   = 0;

    // io windows, compared on address bits 9..3
    localparam addr_t WIN_0 = 10'h3F8;
    localparam addr_t WIN_1 = 10'h2F8;
    localparam addr_t WIN_2 = 10'h3E8;
    localparam addr_t WIN_3 = 10'h2E8;
    localparam int    WIN_LSB = 3;

    // positions in the synchroniser vector
    localparam int A_LSB  = 0;
    localparam int D_LSB  = 10;
    localparam int CE_B   = 18;
    localparam int REG_B  = 19;
    localparam int OE_B   = 20;
    localparam int WE_B   = 21;
    localparam int IORD_B = 22;
    localparam int IOWR_B = 23;
    localparam int CRST_B = 24;
    localparam int IRQ_B  = 25;
    localparam int RDY_B  = 26;
    localparam int SPK_B  = 27;
    localparam int SYNC_W = 28;

    // power-down sequencing
    typedef enum logic [1:0] {
        PM_RUN  = 2'b00,
        PM_DOWN = 2'b01,
        PM_WAKE = 2'b10
    } pm_state_t;

endpackage

// file: hw/ring_if.sv
// ring detect results passed from the detector to the register bank
// assumes both ends run on the same clock
interface ring_if;
    logic ring_start;  // one cycle at each synchronised rising edge
    logic ringing;     // edges arriving within the timeout
    logic ring_level;  // synchronised ring detect level

    modport det (output ring_start, output ringing, output ring_level);
    modport use_side (input ring_start, input ringing, input ring_level);
endinterface

// file: hw/ring_activity_detect.sv
// ring detect synchroniser, cycle start detector and ringing timeout
// assumes the ring pin is asynchronous to the clock
module ring_activity_detect #(
    parameter int unsigned RING_TIMEOUT_CYC = pcc_pkg::RING_TIMEOUT_CYC
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic ring_pin,
    ring_if.det       det
);
    import pcc_pkg::*;

    logic      s1_r;
    logic      s2_r;
    logic      s3_r;
    ring_cnt_t cnt_r;

    // two-flop synchroniser plus one stage for edge detection
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= ring_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
        end else if (s2_r && !s3_r) begin
            cnt_r <= ring_cnt_t'(RING_TIMEOUT_CYC);
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - ring_cnt_t'(1);
        end
    end

    assign det.ring_start = s2_r & ~s3_r;
    assign det.ringing    = (cnt_r != '0);
    assign det.ring_level = s2_r;

endmodule

// file: dv/modem_far_side.sv
// modem-side model: ready, interrupt, ring detect and speaker bits
// assumes the bench requests ringing, interrupt and readiness
module modem_far_side (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic ring_req,
    input  wire logic irq_req,
    input  wire logic rdy_req,
    output logic      ring,
    output logic      irq,
    output logic      rdy,
    output logic      spk
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] ph = 4'h0;
    initial begin
        ring = 1'b0;
        spk = 1'b0;
    end
    // ring toggles every 8 clocks while ringing, low when idle
    always @(posedge clk) begin
        ph <= ph + 4'h1;
        spk <= ph[0];
        ring <= ring_req & ph[3];
    end
    // modem stays busy while held in reset
    assign rdy = rdy_req & reset_n;
    assign irq = irq_req;
endmodule

// file: dv/pc_card_modem_config_decode_tb.sv
// self-checking bench for the modem configuration block
// assumes the modem model drives all modem-side inputs
module pc_card_modem_config_decode_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pcc_pkg::*;
    logic clk = 0, rstn = 0, ce_n = 1, reg_n = 1, oe_n = 1, we_n = 1, iord_n = 1, iowr_n = 1;
    logic crst = 0, ring_req = 0, irq_req = 0, rdy_req = 0, seen = 0;
    logic ring, irqi, rdy, spk, doe, cis_n, mcs_n, ack_n, irq_n, stsc_n, spk_o, spk_oe, ra, rb, modem_reset_n_n, pd_n;
    logic [2:0] sp_hist = 3'h0;
    addr_t addr = 10'h000;
    data_t din = 8'h00, dout;
    int error_cnt = 0, checks = 0;
    // 125 MHz clock
    always #4 clk = ~clk;
    // speaker input history, three cycles matches the pin sync plus output flop
    always @(posedge clk) sp_hist <= {sp_hist[1:0], spk};
    pc_card_modem_config_decode #(.RING_TIMEOUT_CYC(200), .WAKE_PULSE_CYC(8)) u_pc_card_modem_config_decode (
        .CLK(clk), .RSTN(rstn), .ADDR(addr), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe),
        .CARD_ENABLE_N(ce_n), .REG_SELECT_N(reg_n), .OUTPUT_ENABLE_N(oe_n), .WRITE_ENABLE_N(we_n),
        .IO_READ_N(iord_n), .IO_WRITE_N(iowr_n), .CARD_RESET(crst), .RING_DETECT_IN(ring),
        .MODEM_IRQ_IN(irqi), .MODEM_READY_IN(rdy), .SPEAKER_BIT_IN(spk), .INFO_TABLE_CHIP_SELECT_N(cis_n),
        .MODEM_CHIP_SELECT_N(mcs_n), .INPUT_ACK_N(ack_n), .IRQ_READY_N(irq_n), .STATUS_CHANGE_N(stsc_n),
        .SPEAKER_BIT_OUT(spk_o), .SPEAKER_BIT_OE(spk_oe), .RING_OUT_FIRST_FAMILY(ra),
        .RING_OUT_SECOND_FAMILY(rb), .MODEM_RESET_N(modem_reset_n_n), .POWER_DOWN_N(pd_n));
    modem_far_side u_modem_far_side (.clk(clk), .reset_n(modem_reset_n_n), .ring_req(ring_req), .irq_req(irq_req),
        .rdy_req(rdy_req), .ring(ring), .irq(irqi), .rdy(rdy), .spk(spk));
    task conclude;
        if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // start an attribute (reg low) or common cycle, read or write
    task acc(input addr_t a, input data_t d, input logic w, input logic r);
        @(posedge clk);
        addr <= a; din <= d; ce_n <= 1'b0; reg_n <= r;
        if (w) we_n <= 1'b0;
        else oe_n <= 1'b0;
        cyc(5);
    endtask
    // release all strobes, noting any wake pulse
    task idle;
        @(posedge clk);
        {ce_n, reg_n, we_n, oe_n, iord_n, iowr_n} <= 6'h3F;
        repeat (6) begin @(posedge clk); seen |= rb; end
    endtask
    task wr(input addr_t a, input data_t d);
        acc(a, d, 1'b1, 1'b0); idle;
    endtask
    task rd(input addr_t a, input data_t e);
        acc(a, 8'h00, 1'b0, 1'b0); chk(doe, 1'b1); chk(dout, e); idle;
    endtask
    // io read, or io write when w is set; acknowledge only answers reads
    task io(input addr_t a, input logic e, input logic w = 1'b0);
        @(posedge clk);
        addr <= a; ce_n <= 1'b0; reg_n <= 1'b0; iord_n <= w; iowr_n <= ~w;
        cyc(5); chk(mcs_n, e); chk(ack_n, e | w); idle;
    endtask
    task t_reset;
        rd(OFS_COR, 8'h00); rd(OFS_CARD_CONFIG_STATUS, 8'h00); rd(OFS_PRR, 8'h00); rd(OFS_IOE, 8'h00);
        chk(irq_n, 1'b0);
    endtask
    task t_ready;
        rdy_req <= 1'b1;
        for (int i = 0; i < 50 && irq_n !== 1'b1; i++) @(posedge clk);
        if (irq_n !== 1'b1) begin error_cnt++; conclude; end
        rd(OFS_PRR, 8'h22);
        wr(OFS_PRR, 8'h20); rd(OFS_PRR, 8'h22);
        wr(OFS_PRR, 8'h02); rd(OFS_PRR, 8'h02);
    endtask
    task t_decode;
        acc(OFS_CARD_CONFIG_STATUS, 8'h00, 1'b0, 1'b1); chk(doe, 1'b0); chk(cis_n, 1'b1); idle;
        acc(10'h201, 8'h00, 1'b0, 1'b0); chk(doe, 1'b0); idle;
        acc(10'h1FE, 8'h00, 1'b0, 1'b0); chk(cis_n, 1'b0); idle;
        wr(OFS_COR, 8'h20); io(WIN_0, 1'b0); io(WIN_1, 1'b1); io(10'h3FF, 1'b0);
        wr(OFS_COR, 8'h21); io(WIN_1, 1'b0); io(WIN_2, 1'b1);
        wr(OFS_COR, 8'h22); io(WIN_2, 1'b0); io(WIN_3, 1'b1);
        wr(OFS_COR, 8'h23); io(WIN_3, 1'b0); io(WIN_0, 1'b1);
        wr(OFS_COR, 8'h30); io(10'h124, 1'b0); io(10'h124, 1'b0, 1'b1);
        io(WIN_1, 1'b0, 1'b1); wr(OFS_COR, 8'h00); io(WIN_0, 1'b1); io(WIN_0, 1'b1, 1'b1);
    endtask
    task t_power;
        wr(OFS_COR, 8'h20); irq_req <= 1'b1; wr(OFS_CARD_CONFIG_STATUS, 8'hFF);
        rd(OFS_CARD_CONFIG_STATUS, 8'h5E); chk(irq_n, 1'b0);
        chk(spk_oe, 1'b1); chk({ra, rb}, 2'b00); io(WIN_0, 1'b1);
        chk(pd_n, 1'b0);
        repeat (4) begin @(posedge clk); chk(spk_o, sp_hist[2]); end
        irq_req <= 1'b0; seen = 1'b0; wr(OFS_CARD_CONFIG_STATUS, 8'h00);
        // chip select stays blocked for the wake pulse, so let it finish first
        chk(seen, 1'b1); chk(spk_oe, 1'b0); chk(pd_n, 1'b1); cyc(10); io(WIN_0, 1'b0);
    endtask
    task t_ring;
        wr(OFS_IOE, 8'h01); wr(OFS_CARD_CONFIG_STATUS, 8'h40); ring_req <= 1'b1; cyc(40);
        rd(OFS_IOE, 8'h11); rd(OFS_CARD_CONFIG_STATUS, 8'hC0); chk(stsc_n, 1'b0);
        wr(OFS_CARD_CONFIG_STATUS, 8'h50); chk(stsc_n, 1'b0); ring_req <= 1'b0; cyc(260); chk(stsc_n, 1'b1);
        wr(OFS_IOE, 8'h00); rd(OFS_IOE, 8'h10); rd(OFS_CARD_CONFIG_STATUS, 8'h50);
        wr(OFS_CARD_CONFIG_STATUS, 8'h00); chk(stsc_n, 1'b1); wr(OFS_IOE, 8'h10); rd(OFS_IOE, 8'h00);
    endtask
    task t_resets;
        wr(OFS_CARD_CONFIG_STATUS, 8'h08); wr(OFS_COR, 8'h80); chk(modem_reset_n_n, 1'b0); rd(OFS_COR, 8'h80);
        rd(OFS_CARD_CONFIG_STATUS, 8'h00); wr(OFS_COR, 8'h00); chk(modem_reset_n_n, 1'b1);
        wr(OFS_COR, 8'h21); crst <= 1'b1; cyc(6); chk(modem_reset_n_n, 1'b0);
        chk(irq_n, 1'b0); crst <= 1'b0;
        cyc(6); rd(OFS_COR, 8'h00);
    endtask
    initial begin
        cyc(6);
        rstn <= 1'b1;
        t_reset; t_ready; t_decode; t_power; t_ring; t_resets;
        conclude;
    end
endmodule
